// *** multiply_accumulate_shift_unit.sv ***
// Behaviour
// - Unsigned multiply puts the 32-bit product of head and second into product high:low, stack unchanged, interrupts blocked, one cycle.
// - Signed multiply does the same with both operands signed.
// - Reading product high loads it into head, old head into second, old second dropped, interrupts blocked one cycle.
// - Reading product low loads it into head, old head into second, old second dropped, interrupts blocked one cycle.
// - Increment adds one to the index register with wrap from ffff to 0000, stack unchanged.
// - Decrement subtracts one from the index register with wrap from 0000 to ffff, stack unchanged.
// - Zero test makes head ffff when it was zero and 0000 otherwise.
// - Clearing the accumulator zeroes extension, product high and low in one cycle, stack untouched.
// - Double left shift moves head:second left by the low 5 bits of extension into product high:low.
// - Double right arithmetic shift does the same rightward with sign fill.
// - Double right logical shift does the same rightward with zero fill.
// - Writing product high copies head into it, second into head, and pops stack memory into second.
// - Writing product low copies head into it, second into head, and pops stack memory into second.
// - Extension, product high and low form one 48-bit accumulator, extension most significant.
`timescale 1ns/1ns
module multiply_accumulate_shift_unit
    import macs_pkg::*;
#(
    parameter int WIDTH = macs_pkg::DATA_W
) (
    input  wire logic                     i_clk_sys,
    input  wire logic                     i_rst,
    input  wire logic                     i_op_valid,
    input  wire macs_pkg::mac_op_e        i_op,
    input  wire logic [WIDTH-1:0]         i_head,
    input  wire logic [WIDTH-1:0]         i_second,
    input  wire logic [WIDTH-1:0]         i_stack_mem,
    input  wire logic                     i_ext_load,
    input  wire logic [WIDTH-1:0]         i_ext_data,
    output logic      [WIDTH-1:0]         o_head,
    output logic      [WIDTH-1:0]         o_second,
    output logic                          o_head_we,
    output logic                          o_second_we,
    output logic                          o_stack_pop,
    output logic                          o_irq_block,
    output logic      [WIDTH-1:0]         o_index,
    output logic      [WIDTH-1:0]         o_extension,
    output logic      [WIDTH-1:0]         o_product_high,
    output logic      [WIDTH-1:0]         o_product_low
);
    import macs_pkg::*;

    logic [3*WIDTH-1:0] acc_r;
    logic [3*WIDTH-1:0] acc_nxt;

    logic [WIDTH-1:0]   index_r;
    logic [WIDTH-1:0]   index_nxt;

    logic [WIDTH-1:0]   head_r;
    logic [WIDTH-1:0]   head_nxt;
    logic [WIDTH-1:0]   second_r;
    logic [WIDTH-1:0]   second_nxt;

    logic               head_we_r;
    logic               head_we_nxt;
    logic               second_we_r;
    logic               second_we_nxt;
    logic               pop_r;
    logic               pop_nxt;
    logic               irq_block_r;
    logic               irq_block_nxt;

    logic [WIDTH-1:0]   ext_w;
    logic [WIDTH-1:0]   high_w;
    logic [WIDTH-1:0]   low_w;
    logic [2*WIDTH-1:0] product_w;
    logic [2*WIDTH-1:0] shifted_w;
    logic [2*WIDTH-1:0] pair_w;
    logic               op_signed;
    logic               op_left;
    logic               op_arith;

    // One accumulator, viewed as three words
    assign ext_w  = acc_r[EXT_LSB  +: WIDTH];
    assign high_w = acc_r[HIGH_LSB +: WIDTH];
    assign low_w  = acc_r[LOW_LSB  +: WIDTH];
    // Head is the high word of the double-word operand
    assign pair_w = {i_head, i_second};

    // Steering for the two helpers, decoded once
    always_comb begin
        op_signed = 1'b0;
        op_left   = 1'b0;
        op_arith  = 1'b0;
        case (i_op)
            signed_multiply_op: begin
                op_signed = 1'b1;
            end
            double_left_shift_op: begin
                op_left = 1'b1;
            end
            double_right_arith_op: begin
                op_arith = 1'b1;
            end
            default: begin
            end
        endcase
    end

    mac_multiplier #(
        .W(WIDTH)
    ) u_mult (
        .i_head    (i_head),
        .i_second  (i_second),
        .i_signed  (op_signed),
        .o_product (product_w)
    );

    // Count is only the low five bits; upper extension bits are ignored
    mac_double_shifter #(
        .W  (2*WIDTH),
        .SW (SHAMT_W)
    ) u_shift (
        .i_value  (pair_w),
        .i_amount (ext_w[SHAMT_W-1:0]),
        .i_left   (op_left),
        .i_arith  (op_arith),
        .o_result (shifted_w)
    );

    // Accumulator: stores, products, shifts and clear
    always_comb begin
        acc_nxt = acc_r;
        // Multiply and shift leave the extension word alone
        if (i_ext_load) begin
            acc_nxt[EXT_LSB +: WIDTH] = i_ext_data;
        end
        if (i_op_valid) begin
            case (i_op)
                unsigned_multiply_op: begin
                    acc_nxt[0 +: 2*WIDTH] = product_w;
                end
                signed_multiply_op: begin
                    acc_nxt[0 +: 2*WIDTH] = product_w;
                end
                // A store rewrites one word; the other two hold
                write_product_high_op: begin
                    acc_nxt[HIGH_LSB +: WIDTH] = i_head;
                end
                write_product_low_op: begin
                    acc_nxt[LOW_LSB +: WIDTH] = i_head;
                end
                double_left_shift_op: begin
                    acc_nxt[0 +: 2*WIDTH] = shifted_w;
                end
                double_right_arith_op: begin
                    acc_nxt[0 +: 2*WIDTH] = shifted_w;
                end
                double_right_logic_op: begin
                    acc_nxt[0 +: 2*WIDTH] = shifted_w;
                end
                // Clear wins over an extension store in the same cycle
                zero_accumulator_op: begin
                    acc_nxt = {ACC_RESET, ACC_RESET, ACC_RESET};
                end
                default: begin
                end
            endcase
        end
    end

    // Results land on the edge that takes the op
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            acc_r <= {ACC_RESET, ACC_RESET, ACC_RESET};
        end else begin
            acc_r <= acc_nxt;
        end
    end

    // Plain modular arithmetic gives both wraps for free
    always_comb begin
        index_nxt = index_r;
        if (i_op_valid) begin
            case (i_op)
                index_increment_op: begin
                    index_nxt = index_r + WIDTH'(1);
                end
                index_decrement_op: begin
                    index_nxt = index_r - WIDTH'(1);
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            index_r <= INDEX_RESET;
        end else begin
            index_r <= index_nxt;
        end
    end

    // Idle cycles echo the operands; the strobes say when to load
    always_comb begin
        head_nxt   = i_head;
        second_nxt = i_second;
        if (i_op_valid) begin
            case (i_op)
                // Old second is not forwarded: it is lost, never pushed
                read_product_high_op: begin
                    head_nxt   = high_w;
                    second_nxt = i_head;
                end
                read_product_low_op: begin
                    head_nxt   = low_w;
                    second_nxt = i_head;
                end
                write_product_high_op: begin
                    head_nxt   = i_second;
                    second_nxt = i_stack_mem;
                end
                write_product_low_op: begin
                    head_nxt   = i_second;
                    second_nxt = i_stack_mem;
                end
                zero_test_op: begin
                    head_nxt = |i_head ? FALSE_WORD : TRUE_WORD;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            head_r   <= '0;
            second_r <= '0;
        end else begin
            head_r   <= head_nxt;
            second_r <= second_nxt;
        end
    end

    // Strobes to the core; each stands for exactly one cycle
    always_comb begin
        head_we_nxt   = 1'b0;
        second_we_nxt = 1'b0;
        pop_nxt       = 1'b0;
        irq_block_nxt = 1'b0;
        if (i_op_valid) begin
            case (i_op)
                unsigned_multiply_op: begin
                    irq_block_nxt = 1'b1;
                end
                signed_multiply_op: begin
                    irq_block_nxt = 1'b1;
                end
                read_product_high_op: begin
                    head_we_nxt   = 1'b1;
                    second_we_nxt = 1'b1;
                    irq_block_nxt = 1'b1;
                end
                read_product_low_op: begin
                    head_we_nxt   = 1'b1;
                    second_we_nxt = 1'b1;
                    irq_block_nxt = 1'b1;
                end
                write_product_high_op: begin
                    head_we_nxt   = 1'b1;
                    second_we_nxt = 1'b1;
                    pop_nxt       = 1'b1;
                end
                write_product_low_op: begin
                    head_we_nxt   = 1'b1;
                    second_we_nxt = 1'b1;
                    pop_nxt       = 1'b1;
                end
                zero_test_op: begin
                    head_we_nxt = 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            head_we_r   <= 1'b0;
            second_we_r <= 1'b0;
            pop_r       <= 1'b0;
            irq_block_r <= 1'b0;
        end else begin
            head_we_r   <= head_we_nxt;
            second_we_r <= second_we_nxt;
            pop_r       <= pop_nxt;
            irq_block_r <= irq_block_nxt;
        end
    end

    assign o_head         = head_r;
    assign o_second       = second_r;
    assign o_head_we      = head_we_r;
    assign o_second_we    = second_we_r;
    assign o_stack_pop    = pop_r;
    assign o_irq_block    = irq_block_r;
    assign o_index        = index_r;
    assign o_extension    = ext_w;
    assign o_product_high = high_w;
    assign o_product_low  = low_w;
endmodule

// *** macs_pkg.sv ***
package macs_pkg;

    localparam int DATA_W  = 16;
    localparam int PROD_W  = 32;
    localparam int ACC_W   = 48;
    localparam int SHAMT_W = 5;

    // Field positions inside the 48-bit accumulator
    localparam int EXT_LSB  = 32;
    localparam int HIGH_LSB = 16;
    localparam int LOW_LSB  = 0;

    // Reset values and zero-test result words
    localparam logic [15:0] ACC_RESET   = 16'h0000;
    localparam logic [15:0] INDEX_RESET = 16'h0000;
    localparam logic [15:0] TRUE_WORD   = 16'hffff;
    localparam logic [15:0] FALSE_WORD  = 16'h0000;

    // Every operation of this unit completes in one cycle
    localparam int OP_CYCLES = 1;

    typedef enum logic [3:0] {
        nop_op,
        unsigned_multiply_op,
        signed_multiply_op,
        read_product_high_op,
        read_product_low_op,
        write_product_high_op,
        write_product_low_op,
        double_left_shift_op,
        double_right_arith_op,
        double_right_logic_op,
        zero_accumulator_op,
        index_increment_op,
        index_decrement_op,
        zero_test_op
    } mac_op_e;

    typedef enum logic [1:0] {
        stack_hold,
        stack_push_keep,
        stack_pop,
        stack_replace_head
    } stack_move_e;

endpackage

// *** mac_multiplier.sv ***
`timescale 1ns/1ns
module mac_multiplier #(
    parameter int W = 16
) (
    input  wire logic [W-1:0]   i_head,
    input  wire logic [W-1:0]   i_second,
    input  wire logic           i_signed,
    output logic      [2*W-1:0] o_product
);
    logic [2*W-1:0] prod_u;
    logic [2*W-1:0] prod_s;

    always_comb begin
        prod_u    = {{W{1'b0}}, i_head} * {{W{1'b0}}, i_second};
        // Sign-extend first: the low 2W bits of the product are then exact
        prod_s    = {{W{i_head[W-1]}}, i_head} * {{W{i_second[W-1]}}, i_second};
        o_product = i_signed ? prod_s : prod_u;
    end
endmodule

// *** mac_double_shifter.sv ***
`timescale 1ns/1ns
module mac_double_shifter #(
    parameter int W  = 32,
    parameter int SW = 5
) (
    input  wire logic [W-1:0]  i_value,
    input  wire logic [SW-1:0] i_amount,
    input  wire logic          i_left,
    input  wire logic          i_arith,
    output logic      [W-1:0]  o_result
);
    always_comb begin
        if (i_left) begin
            o_result = i_value << i_amount;
        end else if (i_arith) begin
            o_result = W'($signed(i_value) >>> i_amount);
        end else begin
            o_result = i_value >> i_amount;
        end
    end
endmodule

// *** macs_chk.sv ***
`timescale 1ns/1ns
module macs_chk
    import macs_pkg::*;
(
    input wire logic                i_clk_sys,
    input wire logic                i_rst,
    input wire logic                i_op_valid,
    input wire macs_pkg::mac_op_e   i_op,
    input wire logic [15:0]         i_head,
    input wire logic [15:0]         i_second,
    input wire logic [15:0]         i_stack_mem,
    input wire logic [15:0]         o_head,
    input wire logic [15:0]         o_second,
    input wire logic                o_head_we,
    input wire logic                o_second_we,
    input wire logic                o_stack_pop,
    input wire logic                o_irq_block,
    input wire logic [15:0]         o_index,
    input wire logic [15:0]         o_extension,
    input wire logic [15:0]         o_product_high,
    input wire logic [15:0]         o_product_low
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    function automatic logic hit(input mac_op_e c);
        return i_op_valid && i_op == c;
    endfunction

    a_mult_unsigned: assert property (hit(unsigned_multiply_op) |=>
        o_irq_block && !o_head_we && {o_product_high, o_product_low} ==
        $past(i_head) * $past(i_second)) else $error("unsigned product wrong");
    a_mult_signed: assert property (hit(signed_multiply_op) |=>
        {o_product_high, o_product_low} ==
        32'($signed($past(i_head)) * $signed($past(i_second))))
        else $error("signed product wrong");
    a_read_high: assert property (hit(read_product_high_op) |=>
        o_head_we && o_second_we && o_irq_block &&
        o_head == $past(o_product_high) && o_second == $past(i_head))
        else $error("read high wrong");
    a_write_low: assert property (hit(write_product_low_op) |=>
        o_stack_pop && o_product_low == $past(i_head) &&
        o_head == $past(i_second) && o_second == $past(i_stack_mem))
        else $error("write low wrong");
    a_index_step: assert property (hit(index_increment_op) |=>
        o_index == $past(o_index) + 16'h0001) else $error("increment wrong");
    a_zero_test: assert property (hit(zero_test_op) |=> o_head_we &&
        o_head == ($past(i_head) == 16'h0000 ? TRUE_WORD : FALSE_WORD))
        else $error("zero test wrong");
    a_clear_acc: assert property (hit(zero_accumulator_op) |=>
        {o_extension, o_product_high, o_product_low} == 48'h0)
        else $error("clear wrong");
    a_shift_left: assert property (hit(double_left_shift_op) |=>
        {o_product_high, o_product_low} == {$past(i_head), $past(i_second)}
        << ($past(o_extension) & 16'h001f)) else $error("left shift wrong");
endmodule

bind multiply_accumulate_shift_unit macs_chk chk_i (.i_clk_sys, .i_rst,
    .i_op_valid, .i_op, .i_head, .i_second, .i_stack_mem, .o_head, .o_second,
    .o_head_we, .o_second_we, .o_stack_pop, .o_irq_block, .o_index,
    .o_extension, .o_product_high, .o_product_low);

// *** core_stack_model.sv ***
`timescale 1ns/1ns
module core_stack_model (
    input  wire logic        i_clk_sys,
    input  wire logic [15:0] i_new_head,
    input  wire logic [15:0] i_new_second,
    input  wire logic        i_head_we,
    input  wire logic        i_second_we,
    input  wire logic        i_pop,
    output logic      [15:0] o_head,
    output logic      [15:0] o_second,
    output logic      [15:0] o_mem
);
    // Loads mid-cycle so the next instruction already sees the answer
    always @(negedge i_clk_sys) begin
        if (i_head_we) begin
            o_head = i_new_head;
        end
        if (i_second_we) begin
            o_second = i_new_second;
        end
        // Popped word is gone; the next one differs on purpose
        if (i_pop) begin
            o_mem = ~o_mem;
        end
    end
endmodule

// *** multiply_accumulate_shift_unit_tb_top.sv ***
`timescale 1ns/1ns
module multiply_accumulate_shift_unit_tb_top;
    import macs_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        valid = 1'b0;
    logic        ext_load = 1'b0;
    logic [15:0] ext_data = 16'h0000;
    mac_op_e     op = nop_op;
    logic [15:0] head, second, mem, n_head, n_second, index, ext, hi, lo;
    logic        hwe, swe, pop, irqb;
    int          mismatches = 0;
    int          comparisons = 0;
    int          cycles = 0;
    mac_op_e     sops [3] = '{double_left_shift_op, double_right_arith_op,
                              double_right_logic_op};
    logic [31:0] sexp [3] = '{32'h00000010, 32'hf8000000, 32'h08000000};

    always #25 clk = ~clk;

    multiply_accumulate_shift_unit dut (.i_clk_sys(clk), .i_rst(rst),
        .i_op_valid(valid), .i_op(op), .i_head(head), .i_second(second),
        .i_stack_mem(mem), .i_ext_load(ext_load), .i_ext_data(ext_data),
        .o_head(n_head), .o_second(n_second), .o_head_we(hwe),
        .o_second_we(swe), .o_stack_pop(pop), .o_irq_block(irqb),
        .o_index(index), .o_extension(ext), .o_product_high(hi),
        .o_product_low(lo));
    core_stack_model stk (.i_clk_sys(clk), .i_new_head(n_head),
        .i_new_second(n_second), .i_head_we(hwe), .i_second_we(swe),
        .i_pop(pop), .o_head(head), .o_second(second), .o_mem(mem));

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [47:0] exp,
                       input logic [47:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Valid is held high across calls so back-to-back ops never toggle the strobe
    task automatic run(input mac_op_e c);
        valid = 1'b1;
        op = c;
        @(negedge clk);
    endtask

    task automatic idle(input string name);
        valid = 1'b0;
        op = nop_op;
        @(negedge clk);
        $display("test %s finished", name);
    endtask

    task automatic setstk(input logic [15:0] h, s, m);
        stk.o_head = h;
        stk.o_second = s;
        stk.o_mem = m;
    endtask

    task automatic t_mult();
        setstk(16'hffff, 16'hffff, 16'h1111);
        run(unsigned_multiply_op);
        chk("umul", 48'h1fffe0001, {irqb, hi, lo});
        chk("umul stack", 48'h0, {hwe, swe, pop});
        run(signed_multiply_op);
        chk("smul", 48'h100000001, {irqb, hi, lo});
        run(read_product_low_op);
        chk("rdlo", 48'h70001ffff, {hwe, swe, irqb, n_head, n_second});
        run(read_product_high_op);
        chk("rdhi", 48'h700000001, {hwe, swe, irqb, n_head, n_second});
        idle("mult");
    endtask

    task automatic t_write();
        setstk(16'h1234, 16'h5678, 16'h9abc);
        run(write_product_high_op);
        chk("wrhi", 48'h123456789abc, {hi, n_head, n_second});
        chk("wrhi flags", 48'h7, {pop, hwe, swe});
        run(write_product_low_op);
        chk("wrlo", 48'h56789abc6543, {lo, n_head, n_second});
        idle("write");
    endtask

    task automatic t_index();
        run(index_decrement_op);
        chk("dec", 48'hffff0000, {index, 13'h0, hwe, swe, pop});
        run(index_increment_op);
        chk("inc", 48'h0, {index, 13'h0, hwe, swe, pop});
        idle("index");
    endtask

    task automatic t_zero();
        setstk(16'h0000, 16'h0002, 16'h0000);
        run(zero_test_op);
        chk("zero", 48'h1ffff, {hwe, n_head});
        run(zero_test_op);
        chk("nonzero", 48'h10000, {hwe, n_head});
        idle("zero");
    endtask

    task automatic t_shift();
        ext_load = 1'b1;
        ext_data = 16'h0004;
        @(negedge clk);
        ext_load = 1'b0;
        setstk(16'h8000, 16'h0001, 16'h0000);
        for (int k = 0; k < 3; k++) begin
            run(sops[k]);
            chk("shift", {16'h0004, sexp[k]}, {ext, hi, lo});
        end
        run(zero_accumulator_op);
        chk("clear", 48'h0, {ext, hi, lo});
        idle("shift");
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            $display("wrong value cycles expected below 2000 seen %0d", cycles);
            close_out();
        end
    end

    initial begin
        setstk(16'h0000, 16'h0000, 16'h0000);
        repeat (5) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk("reset", 48'h0, {ext, hi, lo});
        t_mult();
        t_write();
        t_index();
        t_zero();
        t_shift();
        close_out();
    end
endmodule
